// File: rtl/hrd_checker.sv
// Pre-decoder buffer fullness model and leaky-bucket checker
`timescale 1ns/100ps
`default_nettype none
module hrd_checker #(
	parameter int CLK_HZ = hrd_pkg::CLK_HZ,
	parameter int DEPTH = hrd_pkg::DEPTH,
	parameter int AW = $clog2(DEPTH)
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// Configuration
	input wire hrd_pkg::hrd_cfg_t cfg_in,
	input wire logic flag_clr_in,
	// Picture descriptors
	input wire logic pic_valid_in,
	input wire hrd_pkg::hrd_pic_t pic_in,
	output logic pic_ready_out,
	// Status
	output logic [31:0] fullness_out,
	output logic [31:0] bucket_out,
	output logic removed_out,
	output logic tick_out,
	output hrd_pkg::hrd_flag_t flags_out,
	output logic contained_out
);
	localparam logic [32:0] HZ = 33'(CLK_HZ);

	// Time base
	logic started_q, started_d;
	logic [32:0] uacc_q, uacc_d, bacc_q, bacc_d;
	logic [31:0] ucnt_q, ucnt_d, tick_q, tick_d;
	logic tickp_q, tickp_d, bitp_q, bitp_d;

	// Model state
	logic [31:0] sz_q [DEPTH];
	logic [31:0] sz_d [DEPTH];
	logic [31:0] tr_q [DEPTH];
	logic [31:0] tr_d [DEPTH];
	logic [AW:0] wr_q, wr_d, arr_q, arr_d, rd_q, rd_d;
	logic [31:0] last_tr_q, last_tr_d, tr0_q, tr0_d, left_q, left_d;
	logic [31:0] full_q, full_d, lvl_q, lvl_d;
	hrd_pkg::hrd_arr_t state_q, state_d;
	hrd_pkg::hrd_flag_t flg_q, flg_d;
	logic prev_q, prev_d, lbrun_q, lbrun_d, rem_q, rdy_q, rdy_d;

	logic acc, bit_in, fin, hd_done, due, rem;
	logic [AW-1:0] hd, ai;
	logic [31:0] earliest, hd_sz;
	logic [32:0] lb_sum, bf_pre;
	logic [AW:0] cnt_next;

	// Unit and bit rates come from phase accumulators, so no divider is needed
	always_comb begin
		started_d = started_q | acc;
		uacc_d = uacc_q;
		bacc_d = bacc_q;
		ucnt_d = ucnt_q;
		tick_d = tick_q;
		tickp_d = 1'b0;
		bitp_d = 1'b0;
		if (started_q) begin
			uacc_d = uacc_q + {1'b0, cfg_in.time_scale};
			if (uacc_d >= HZ) begin
				uacc_d = uacc_d - HZ;
				if (ucnt_q + 32'h0000_0001 >= cfg_in.units_per_tick) begin
					ucnt_d = hrd_pkg::ZERO32;
					tickp_d = 1'b1;
					tick_d = tick_q + 32'h0000_0001;
				end else begin
					ucnt_d = ucnt_q + 32'h0000_0001;
				end
			end
			bacc_d = bacc_q + {1'b0, cfg_in.bit_rate};
			if (bacc_d >= HZ) begin
				bacc_d = bacc_d - HZ;
				bitp_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			started_q <= 1'b0;
			uacc_q <= 33'h0_0000_0000;
			bacc_q <= 33'h0_0000_0000;
			ucnt_q <= 32'h0000_0000;
			tick_q <= 32'h0000_0000;
			tickp_q <= 1'b0;
			bitp_q <= 1'b0;
		end else begin
			started_q <= started_d;
			uacc_q <= uacc_d;
			bacc_q <= bacc_d;
			ucnt_q <= ucnt_d;
			tick_q <= tick_d;
			tickp_q <= tickp_d;
			bitp_q <= bitp_d;
		end
	end

	always_comb begin
		acc = pic_valid_in & rdy_q;
		hd = rd_q[AW-1:0];
		ai = arr_q[AW-1:0];
		hd_sz = sz_q[hd];
		earliest = tr_q[ai] - tr0_q;
		bit_in = (state_q == hrd_pkg::ARR_RUN) && bitp_q && (left_q != hrd_pkg::ZERO32);
		fin = (state_q == hrd_pkg::ARR_RUN) &&
			((left_q == hrd_pkg::ZERO32) || (bit_in && left_q == 32'h0000_0001));
		hd_done = (rd_q != arr_q) || fin;
		due = tickp_q && (wr_q != rd_q) && (tick_q >= tr_q[hd]);
		rem = due && hd_done;
		sz_d = sz_q;
		tr_d = tr_q;
		wr_d = wr_q;
		arr_d = arr_q;
		rd_d = rd_q;
		last_tr_d = last_tr_q;
		tr0_d = tr0_q;
		left_d = left_q;
		state_d = state_q;
		prev_d = prev_q;
		lvl_d = lvl_q;
		lbrun_d = lbrun_q;
		flg_d = flag_clr_in ? 4'h0 : flg_q;
		// Removal times are kept in ticks, so tr(0) aligns with tick edges
		if (acc) begin
			sz_d[wr_q[AW-1:0]] = pic_in.bits;
			if (!started_q) begin
				tr_d[wr_q[AW-1:0]] = cfg_in.init_ticks;
				last_tr_d = cfg_in.init_ticks;
				tr0_d = cfg_in.init_ticks;
				lvl_d = cfg_in.lb_size - cfg_in.lb_init;
			end else begin
				tr_d[wr_q[AW-1:0]] = last_tr_q + pic_in.delay;
				last_tr_d = last_tr_q + pic_in.delay;
			end
			wr_d = wr_q + 1'b1;
		end
		unique case (state_q)
			hrd_pkg::ARR_IDLE: begin
				if (arr_q != wr_q) begin
					state_d = hrd_pkg::ARR_WAIT;
				end
			end
			hrd_pkg::ARR_WAIT: begin
				// Waiting for earliest arrival caps removal delay at tr(0)
				if (tick_q >= earliest) begin
					state_d = hrd_pkg::ARR_RUN;
					left_d = sz_q[ai];
				end else if (cfg_in.cbr && prev_q) begin
					flg_d.gap = 1'b1;
				end
			end
			hrd_pkg::ARR_RUN: begin
				if (bit_in) begin
					left_d = left_q - 32'h0000_0001;
				end
				// Next queued picture passes through ARR_WAIT for a cycle first, so a bit slot can be lost between pictures
				if (fin) begin
					arr_d = arr_q + 1'b1;
					prev_d = 1'b1;
					state_d = (arr_d != wr_d) ? hrd_pkg::ARR_WAIT : hrd_pkg::ARR_IDLE;
				end
			end
			default: state_d = hrd_pkg::ARR_IDLE;
		endcase
		// Low-delay mode holds a late head until it completes, then removes at a tick
		if (due && !hd_done && !cfg_in.low_delay) begin
			flg_d.udf = 1'b1;
		end
		bf_pre = {1'b0, full_q} + {32'h0000_0000, bit_in};
		if (rem && bf_pre > {1'b0, cfg_in.buf_size}) begin
			flg_d.ovf = 1'b1;
		end
		full_d = full_q + {31'h0000_0000, bit_in};
		lb_sum = {1'b0, lvl_q} + {1'b0, hd_sz};
		if (rem) begin
			rd_d = rd_q + 1'b1;
			full_d = full_d - hd_sz;
			if (lb_sum > {1'b0, cfg_in.lb_size}) begin
				flg_d.lb_fail = 1'b1;
			end
			lvl_d = lb_sum[31:0];
			lbrun_d = 1'b1;
		end else if (lbrun_q && bitp_q && lvl_q != hrd_pkg::ZERO32) begin
			lvl_d = lvl_q - 32'h0000_0001;
		end
		cnt_next = wr_d - rd_d;
		rdy_d = (cnt_next != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				sz_q[i] <= 32'h0000_0000;
				tr_q[i] <= 32'h0000_0000;
			end
			wr_q <= '0;
			arr_q <= '0;
			rd_q <= '0;
			last_tr_q <= 32'h0000_0000;
			tr0_q <= 32'h0000_0000;
			left_q <= 32'h0000_0000;
			full_q <= 32'h0000_0000;
			lvl_q <= 32'h0000_0000;
			state_q <= hrd_pkg::ARR_IDLE;
			flg_q <= 4'h0;
			prev_q <= 1'b0;
			lbrun_q <= 1'b0;
			rem_q <= 1'b0;
			rdy_q <= 1'b0;
		end else begin
			sz_q <= sz_d;
			tr_q <= tr_d;
			wr_q <= wr_d;
			arr_q <= arr_d;
			rd_q <= rd_d;
			last_tr_q <= last_tr_d;
			tr0_q <= tr0_d;
			left_q <= left_d;
			full_q <= full_d;
			lvl_q <= lvl_d;
			state_q <= state_d;
			flg_q <= flg_d;
			prev_q <= prev_d;
			lbrun_q <= lbrun_d;
			rem_q <= rem;
			rdy_q <= rdy_d;
		end
	end

	assign pic_ready_out = rdy_q;
	assign fullness_out = full_q;
	assign bucket_out = lvl_q;
	assign removed_out = rem_q;
	assign tick_out = tickp_q;
	assign flags_out = flg_q;
	assign contained_out = ~flg_q.lb_fail;

	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	AST_FULL_ON_REMOVE: assert property (rem |=>
		full_q == $past(full_q) + 32'($past(bit_in)) - $past(hd_sz))
		else $error("fullness did not drop by removed picture size");
	AST_START_NOT_EARLY: assert property (
		(state_q == hrd_pkg::ARR_RUN && $past(state_q) == hrd_pkg::ARR_WAIT)
		|-> $past(tick_q) >= $past(earliest))
		else $error("arrival started before earliest arrival time");
	AST_REMOVE_AT_TICK: assert property (rem_q |->
		$past(tickp_q) && $past(tick_q) >= $past(tr_q[hd]))
		else $error("picture removed before its removal tick");
	AST_UNDERFLOW: assert property (
		(due && !hd_done && !cfg_in.low_delay) |=> flags_out.udf)
		else $error("late picture did not raise underflow");
	AST_LOWDELAY_HOLD: assert property (
		(due && !hd_done) |=> !removed_out)
		else $error("incomplete picture was removed");
	AST_OVERFLOW: assert property (
		(rem && bf_pre > {1'b0, cfg_in.buf_size}) |=> flags_out.ovf)
		else $error("overflow before removal not flagged");
	AST_VBR_NO_GAP: assert property (
		(!cfg_in.cbr && !flags_out.gap) |=> !flags_out.gap)
		else $error("gap flagged in variable rate mode");
	AST_BUCKET_FAIL: assert property (
		(rem && lb_sum > {1'b0, cfg_in.lb_size}) |=> !contained_out)
		else $error("bucket overflow not reported");
	AST_BUCKET_CLAMP: assert property (
		(started_q && lvl_q == hrd_pkg::ZERO32 && !rem) |=> lvl_q == hrd_pkg::ZERO32)
		else $error("bucket level left zero without insertion");
	AST_STICKY: assert property (
		(flags_out.ovf && !flag_clr_in) |=> flags_out.ovf)
		else $error("overflow flag not sticky");
	AST_GAP_SET: assert property (
		(state_q == hrd_pkg::ARR_WAIT && tick_q < earliest && cfg_in.cbr && prev_q)
		|=> flags_out.gap)
		else $error("arrival gap in constant rate mode not flagged");
	AST_LEAK: assert property (
		(lbrun_q && bitp_q && !rem && lvl_q != hrd_pkg::ZERO32)
		|=> bucket_out == $past(lvl_q) - 32'h0000_0001)
		else $error("bucket did not leak one bit");
	AST_BUCKET_LOAD: assert property (
		(acc && !started_q) |=> bucket_out == $past(cfg_in.lb_size) - $past(cfg_in.lb_init))
		else $error("bucket not loaded with size minus fullness");
	AST_ARRIVAL_BITS: assert property (
		!rem |=> fullness_out == $past(full_q) + 32'($past(bit_in)))
		else $error("fullness moved by other than one arriving bit");
	AST_RUN_HOLD: assert property (
		(state_q == hrd_pkg::ARR_RUN && !bitp_q) |=> left_q == $past(left_q))
		else $error("bits counted without a bit slot");
	AST_LOWDELAY_NO_UDF: assert property (
		(cfg_in.low_delay && !flags_out.udf) |=> !flags_out.udf)
		else $error("underflow flagged in low delay mode");
	AST_FIRST_NOT_EARLY: assert property (
		rem |-> tick_q >= tr0_q)
		else $error("picture removed before first removal time");
	AST_TICK_STARTED: assert property (
		tick_out |-> started_q)
		else $error("tick counted before time base started");
	AST_READY_FULL: assert property (
		(wr_q - rd_q == (AW+1)'(DEPTH)) |-> !pic_ready_out)
		else $error("descriptor accepted with queue full");
endmodule
`default_nettype wire

// File: rtl/hrd_pkg.sv
// Shared constants and types for the pre-decoder buffer checker
// Overview of operation
// - Fullness is arrived unremoved pictures plus bits of the arriving picture so far.
// - Low-delay: removal delay from arrival start can exceed first removal delay for a late picture.
// - Late isolated big picture leaves at first tick boundary at or after final arrival.
// - Underflow avoided only if final arrival is no later than removal time.
// - Constant-rate mode: no arrival gaps before next picture's earliest start.
// - Variable-rate mode accepts arrival gaps, still checks empty and full limits.
// - Overflow checked just before each removal, underflow just after.
// - Bucket starts at size minus fullness, adds pictures, leaks, clamps at zero.
// - Containment holds only if level plus inserted bits never exceeds size.
// - Contained stream neither overflows nor underflows a decoder with same parameters.
// - Removal time is previous removal time plus tick times signalled count.
// - Arrival starts at previous final arrival, but not before earliest arrival.
// - Arrival lasts picture size divided by bit rate.
package hrd_pkg;
	localparam int CLK_NS = 4;
	localparam int CLK_HZ = 1000000000 / CLK_NS;
	localparam int DW = 32;
	localparam int DEPTH = 4;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;

	typedef struct packed {
		logic [31:0] time_scale;
		logic [31:0] units_per_tick;
		logic [31:0] bit_rate;
		logic [31:0] buf_size;
		logic [31:0] init_ticks;
		logic [31:0] lb_size;
		logic [31:0] lb_init;
		logic low_delay;
		logic cbr;
	} hrd_cfg_t;

	typedef struct packed {
		logic [31:0] bits;
		logic [31:0] delay;
	} hrd_pic_t;

	typedef struct packed {
		logic ovf;
		logic udf;
		logic gap;
		logic lb_fail;
	} hrd_flag_t;

	typedef enum logic [1:0] {
		ARR_IDLE = 2'b00,
		ARR_WAIT = 2'b01,
		ARR_RUN = 2'b11
	} hrd_arr_t;
endpackage

// File: test/hrd_checker_tb.sv
// Self-checking bench for the buffer and bucket checker
`timescale 1ns/100ps
`default_nettype none
module hrd_checker_tb;
	localparam int HZ = 1000;
	logic clk_in = 1'h0;
	logic rstn_in = 1'h0;
	logic flag_clr_in = 1'h0;
	hrd_pkg::hrd_cfg_t cfg_in = '0;
	logic pic_valid_in;
	hrd_pkg::hrd_pic_t pic_in;
	logic pic_ready_out;
	logic [31:0] fullness_out;
	logic [31:0] bucket_out;
	logic removed_out;
	logic tick_out;
	hrd_pkg::hrd_flag_t flags_out;
	logic contained_out;
	int fails = 0;
	int comparisons = 0;
	int cyc = 0;
	int nrem = 0;
	int last = 0;
	int ival = 0;
	int tlast = 0;
	int tper = 0;
	int c0 = 0;
	logic [31:0] dly [16];
	always #2 clk_in = ~clk_in;
	hrd_checker #(.CLK_HZ(HZ)) uut (.clk_in(clk_in), .rstn_in(rstn_in), .cfg_in(cfg_in),
		.flag_clr_in(flag_clr_in), .pic_valid_in(pic_valid_in), .pic_in(pic_in),
		.pic_ready_out(pic_ready_out), .fullness_out(fullness_out), .bucket_out(bucket_out),
		.removed_out(removed_out), .tick_out(tick_out), .flags_out(flags_out),
		.contained_out(contained_out));
	hrd_src src (.clk_in(clk_in), .rstn_in(rstn_in), .ready_in(pic_ready_out),
		.valid_out(pic_valid_in), .pic_out(pic_in));
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (removed_out === 1'h1) begin
			nrem <= nrem + 1;
			ival <= cyc - last;
			last <= cyc;
		end
		if (tick_out === 1'h1) begin
			tper <= cyc - tlast;
			tlast <= cyc;
		end
	end
	function automatic logic [31:0] exp_per();
		return cfg_in.units_per_tick * HZ / cfg_in.time_scale;
	endfunction
	task automatic end_of_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("mismatch %s expected %0h seen %0h", n, e, s);
		end
	endtask
	// Restarts the time base, since the first accepted picture sets tick 0
	task automatic start(input logic [31:0] init, bsz, lbs, input logic ld, cb);
		@(posedge clk_in);
		rstn_in <= 1'h0;
		cfg_in <= '{32'h1F4, 32'h4, 32'h1F4, bsz, init, lbs, lbs - 32'h5, ld, cb};
		repeat (4) @(posedge clk_in);
		rstn_in <= 1'h1;
		@(posedge clk_in);
	endtask
	task automatic wait_rem(input int k);
		int t;
		t = nrem + k;
		for (int i = 0; i < 2000 && nrem < t; i++) begin
			@(posedge clk_in);
			#1;
		end
		if (nrem < t) begin
			fails++;
			$display("mismatch removals expected %0d seen %0d", t, nrem);
			end_of_test();
		end else begin
			@(posedge clk_in);
			#1;
		end
	endtask
	task automatic clr();
		@(posedge clk_in);
		flag_clr_in <= 1'h1;
		@(posedge clk_in);
		flag_clr_in <= 1'h0;
		@(posedge clk_in);
		#1;
	endtask
	initial begin
		void'($urandom(87));
		// Sizes bounded by the next delay so arrival never falls behind
		start(32'h4, 32'h3E8, 32'h3E8, 1'h1, 1'h0);
		for (int i = 0; i < 12; i++)
			dly[i] = $urandom_range(3, 1);
		dly[12] = 32'h1;
		dly[3] = 32'h3;
		for (int i = 0; i < 12; i++)
			src.push((i == 3) ? 32'h0 : $urandom_range(4 * dly[i + 1], 0), dly[i]);
		repeat (6) @(posedge clk_in);
		#1;
		chk("bucket start", 32'h5, bucket_out);
		chk("queue full", 32'h0, 32'(pic_ready_out));
		for (int i = 0; i < 12; i++) begin
			wait_rem(1);
			if (i > 0) chk("removal interval", dly[i] * exp_per() + 1 - 1, ival);
		end
		chk("tick period", exp_per(), tper);
		chk("fullness drained", 32'h0, fullness_out);
		chk("flags clean", 32'h0, 32'(flags_out));
		chk("contained", 32'h1, 32'(contained_out));
		$display("test stream done");
		start(32'h1, 32'h3E8, 32'h3E8, 1'h0, 1'h0);
		src.push(32'h28, 32'h0);
		repeat (40) @(posedge clk_in);
		#1;
		chk("underflow", 32'h1, 32'(flags_out.udf));
		wait_rem(1);
		clr();
		chk("cleared", 32'h0, 32'(flags_out));
		$display("test underflow done");
		start(32'h1, 32'h3E8, 32'h3E8, 1'h1, 1'h0);
		c0 = cyc;
		src.push(32'h28, 32'h0);
		src.push(32'h2, 32'h10);
		wait_rem(1);
		chk("late removal", 32'h1, 32'((cyc - c0) inside {[80:100]}));
		chk("late no underflow", 32'h0, 32'(flags_out.udf));
		wait_rem(1);
		chk("resumed drained", 32'h0, fullness_out);
		$display("test low delay done");
		start(32'h8, 32'h8, 32'h10, 1'h0, 1'h0);
		src.push(32'h10, 32'h0);
		wait_rem(1);
		chk("overflow", 32'h1, 32'(flags_out.ovf));
		chk("bucket fail", 32'h0, 32'(contained_out));
		clr();
		chk("cleared", 32'h0, 32'(flags_out));
		$display("test overflow done");
		start(32'h4, 32'h3E8, 32'h3E8, 1'h0, 1'h1);
		src.push(32'h4, 32'h0);
		src.push(32'h4, 32'h4);
		wait_rem(2);
		chk("gap", 32'h1, 32'(flags_out.gap));
		$display("test gap done");
		end_of_test();
	end
endmodule
`default_nettype wire

// File: test/hrd_src.sv
// Stream source model offering picture descriptors in order
`timescale 1ns/100ps
`default_nettype none
module hrd_src (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// Descriptor handshake
	input wire logic ready_in,
	output logic valid_out,
	output hrd_pkg::hrd_pic_t pic_out
);
	hrd_pkg::hrd_pic_t q[$];
	initial begin
		valid_out = 1'h0;
		pic_out = '0;
	end
	// Queues a descriptor as given; caller may size pictures to overflow the buffer or arrive late
	task automatic push(input logic [31:0] b, input logic [31:0] d);
		q.push_back({b, d});
	endtask
	// Offer held until taken; released data is inverted, not left stale
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			valid_out <= 1'h0;
			pic_out <= ~pic_out;
		end else if (!valid_out || ready_in) begin
			if (valid_out) begin
				void'(q.pop_front());
			end
			valid_out <= (q.size() != 0);
			pic_out <= (q.size() != 0) ? q[0] : ~pic_out;
		end
	end
endmodule
`default_nettype wire
